/* File: core/hwo_option_regs.sv */
// Purpose: Read-only option words and the decoded option controls
// Assumes: Strobes are single cycle; read data valid the cycle after
// Notes:   Contents never change, reset touches only the read path
//
// Summary of operation
// [R1] Word A fixed, read-only, survives reset
// [R2] Top bit keeps voltage monitor alive in stop
// [R3] Bit six blocks external ROM access
// [R4] Bit five lets monitor cause reset
// [R5] Bit four powers the voltage monitor
// [R6] Bit three picks 32 or 4096 recovery
// [R7] Bit two picks watchdog timeout length
// [R8] Bit one allows stop, else illegal opcode
// [R9] Bit zero disables the watchdog
// [R10] Word B selects EEPROM timebase clock source
// [R11] Monitor mode EEPROM blocked until code entered
// [R12] Word B carries fixed variant indicator bit
// [R13] Word B read-only, writes ignored
`timescale 1ns/1ns
module hwo_option_regs #(
    parameter logic [7:0] OPTION_A = 8'h00,

    // Variant indicator value is arbitrary here
    parameter logic       VARIANT  = 1'b0,

    parameter logic       EE_CLK   = 1'b0,

    parameter logic       EE_MON   = 1'b0
) (
    // Clock and reset
    input  wire logic                       sys_clk_i,

    input  wire logic                       sys_rst_i,

    // Register port
    input  wire logic [hwo_pkg::ADDR_W-1:0] reg_addr_i,

    input  wire logic [hwo_pkg::DATA_W-1:0] reg_wdata_i,

    input  wire logic                       reg_wr_i,

    input  wire logic                       reg_rd_i,

    output logic      [hwo_pkg::DATA_W-1:0] reg_rdata_o,

    // Monitor mode status
    input  wire logic                       monitor_mode_i,

    input  wire logic                       sec_code_ok_i,

    // Voltage monitor and ROM protect controls
    output logic                            lowvolt_in_stop_en_o,

    output logic                            rom_read_protect_o,

    output logic                            lowvolt_reset_en_o,

    output logic                            lowvolt_power_en_o,

    // Stop recovery
    output logic                            short_stop_recovery_o,

    output logic      [11:0]                stop_recovery_cycles_o,

    // Watchdog and stop instruction
    output logic                            watchdog_rate_sel_o,

    output logic      [17:0]                watchdog_timeout_cycles_o,

    output logic                            stop_insn_en_o,

    output logic                            watchdog_disable_o,

    output logic                            watchdog_enable_o,

    // EEPROM controls
    output logic                            eeprom_timebase_clk_sel_o,

    output logic                            eeprom_monitor_protect_o,

    output logic                            eeprom_monitor_block_o
);

    // Unused bits between the monitor protect and the variant bit
    localparam int B_FILL_W = hwo_pkg::B_EE_MON - hwo_pkg::B_VARIANT - 1;

    logic [hwo_pkg::DATA_W-1:0] option_word_a;

    logic [hwo_pkg::DATA_W-1:0] option_word_b;

    logic                       hit_a;

    logic                       hit_b;

    logic                       sel_a;

    logic                       sel_b;

    logic [hwo_pkg::DATA_W-1:0] nxt_rdata;

    logic [hwo_pkg::DATA_W-1:0] rdata_ff;

    // Address compare, shared by both option words
    function automatic logic addr_match(
        input logic [hwo_pkg::ADDR_W-1:0] addr,

        input logic [hwo_pkg::ADDR_W-1:0] target
    );

        return addr == target;

    endfunction : addr_match

    // Recovery delay in crystal clock cycles
    function automatic logic [11:0] rec_cycles(
        input logic short_sel
    );

        return short_sel ? hwo_pkg::REC_SHORT_CYC
                         : hwo_pkg::REC_LONG_CYC;

    endfunction : rec_cycles

    // Watchdog timeout in crystal clock cycles
    function automatic logic [17:0] wd_cycles(
        input logic rate_sel
    );

        return rate_sel ? hwo_pkg::WD_SHORT_CYC
                        : hwo_pkg::WD_LONG_CYC;

    endfunction : wd_cycles

    // Hardwired; no flop holds them so no reset can disturb them
    assign option_word_a = OPTION_A; // [R1]

    assign option_word_b = {EE_CLK,
                            EE_MON,
                            {B_FILL_W{1'b0}},
                            VARIANT}; // [R10] [R11] [R12]

    assign hit_a = addr_match(reg_addr_i,
                              hwo_pkg::OPT_A_ADDR);

    assign hit_b = addr_match(reg_addr_i,
                              hwo_pkg::OPT_B_ADDR);

    // Writes are never decoded, so reg_wr_i and reg_wdata_i have no effect
    assign sel_a = reg_rd_i & hit_a; // [R1]

    assign sel_b = reg_rd_i & hit_b; // [R13]

    // Unmapped or idle cycles return zero
    genvar gi;

    generate
        for (gi = 0; gi < hwo_pkg::DATA_W; gi++) begin : g_rd_bit
            assign nxt_rdata[gi] = (sel_a & option_word_a[gi])
                                 | (sel_b & option_word_b[gi]);
        end
    endgenerate

    // Reset clears only the read path, never the options
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            rdata_ff <= hwo_pkg::ZERO_BYTE;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign reg_rdata_o = rdata_ff;

    // Voltage monitor and ROM protect options
    assign lowvolt_in_stop_en_o =
        option_word_a[hwo_pkg::A_LV_STOP]; // [R2]

    assign rom_read_protect_o =
        option_word_a[hwo_pkg::A_ROM_PROT]; // [R3]

    assign lowvolt_reset_en_o =
        option_word_a[hwo_pkg::A_LV_RST]; // [R4]

    assign lowvolt_power_en_o =
        option_word_a[hwo_pkg::A_LV_PWR]; // [R5]

    // Long delay shows as terminal count, one less than the cycle total
    assign short_stop_recovery_o =
        option_word_a[hwo_pkg::A_SHORT_REC]; // [R6]

    assign stop_recovery_cycles_o =
        rec_cycles(short_stop_recovery_o); // [R6]

    // Watchdog and stop instruction options
    assign watchdog_rate_sel_o =
        option_word_a[hwo_pkg::A_WD_RATE]; // [R7]

    assign watchdog_timeout_cycles_o =
        wd_cycles(watchdog_rate_sel_o); // [R7]

    assign stop_insn_en_o =
        option_word_a[hwo_pkg::A_STOP_EN]; // [R8]

    assign watchdog_disable_o =
        option_word_a[hwo_pkg::A_WD_DIS]; // [R9]

    assign watchdog_enable_o =
        !watchdog_disable_o; // [R9]

    // EEPROM options
    assign eeprom_timebase_clk_sel_o =
        option_word_b[hwo_pkg::B_EE_CLK]; // [R10]

    assign eeprom_monitor_protect_o =
        option_word_b[hwo_pkg::B_EE_MON]; // [R11]

    // Blocking lifts as soon as the security code is accepted
    assign eeprom_monitor_block_o =
        eeprom_monitor_protect_o
        & monitor_mode_i
        & !sec_code_ok_i; // [R11]

endmodule : hwo_option_regs

/* File: core/hwo_pkg.sv */
// Purpose: Constants for the hardwired option registers
// Assumes: Byte-wide register port, 125 MHz system clock
// Notes:   Option values are fixed at manufacture
package hwo_pkg;
    localparam int          ADDR_W           = 16;
    localparam int          DATA_W           = 8;
    localparam logic [15:0] OPT_A_ADDR       = 16'h001f;
    localparam logic [15:0] OPT_B_ADDR       = 16'h0020;
    // Word A fields
    localparam int          A_LV_STOP        = 7;
    localparam int          A_ROM_PROT       = 6;
    localparam int          A_LV_RST         = 5;
    localparam int          A_LV_PWR         = 4;
    localparam int          A_SHORT_REC      = 3;
    localparam int          A_WD_RATE        = 2;
    localparam int          A_STOP_EN        = 1;
    localparam int          A_WD_DIS         = 0;
    // Word B fields
    localparam int          B_EE_CLK         = 7;
    localparam int          B_EE_MON         = 6;
    localparam int          B_VARIANT        = 0;
    // Crystal-clock cycle counts, then the read-data reset byte
    localparam logic [11:0] REC_SHORT_CYC    = 12'h020;
    localparam logic [11:0] REC_LONG_CYC     = 12'hfff;
    localparam logic [17:0] WD_SHORT_CYC     = 18'h01ff0;
    localparam logic [17:0] WD_LONG_CYC      = 18'h3fff0;
    localparam logic [7:0]  ZERO_BYTE        = 8'h00;
endpackage : hwo_pkg

/* File: testbench/hwo_option_checker.sv */
// Purpose: Port assertions for the option registers
// Assumes: Options come from parameters; read data one cycle late
// Notes:   Port lists packed to keep the file short
`timescale 1ns/1ns
module hwo_chk #(parameter logic [7:0] OPTION_A = 8'h00, parameter logic EE_CLK = 1'b0, EE_MON = 1'b0, VARIANT = 1'b0) (
    input wire logic        sys_clk_i, sys_rst_i, reg_rd_i, monitor_mode_i, sec_code_ok_i,
    input wire logic [15:0] reg_addr_i,
    input wire logic [7:0]  reg_rdata_o,
    input wire logic        lowvolt_in_stop_en_o, rom_read_protect_o, lowvolt_reset_en_o, lowvolt_power_en_o,
    input wire logic        short_stop_recovery_o, watchdog_rate_sel_o, stop_insn_en_o, watchdog_disable_o,
    input wire logic        watchdog_enable_o, eeprom_timebase_clk_sel_o, eeprom_monitor_protect_o, eeprom_monitor_block_o,
    input wire logic [11:0] stop_recovery_cycles_o,
    input wire logic [17:0] watchdog_timeout_cycles_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);
    sequence s_rd(logic [15:0] a); reg_rd_i && reg_addr_i == a; endsequence
    a_rd_word_a: assert property (s_rd(hwo_pkg::OPT_A_ADDR) |=> reg_rdata_o == OPTION_A) else $error("bad A");
    a_rd_word_b: assert property (s_rd(hwo_pkg::OPT_B_ADDR) |=> reg_rdata_o == {EE_CLK, EE_MON, 5'h00, VARIANT})
        else $error("bad B");
    a_rd_idle: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00) else $error("idle data");
    a_lv_fields: assert property ({lowvolt_in_stop_en_o, rom_read_protect_o, lowvolt_reset_en_o,
        lowvolt_power_en_o} == OPTION_A[7:4]) else $error("lv bits");
    a_stop_rec: assert property (stop_recovery_cycles_o == (OPTION_A[3] ? 12'h020 : 12'hfff)
        && short_stop_recovery_o == OPTION_A[3]) else $error("recovery");
    a_wd_time: assert property (watchdog_timeout_cycles_o == (OPTION_A[2] ? 18'h01ff0 : 18'h3fff0)
        && watchdog_rate_sel_o == OPTION_A[2]) else $error("wd time");
    a_stop_insn: assert property (stop_insn_en_o == OPTION_A[1]) else $error("stop en");
    a_wd_enable: assert property (watchdog_enable_o == !OPTION_A[0] && watchdog_disable_o == OPTION_A[0])
        else $error("wd en");
    a_ee_block: assert property (eeprom_monitor_block_o == (EE_MON && monitor_mode_i && !sec_code_ok_i)
        && eeprom_timebase_clk_sel_o == EE_CLK && eeprom_monitor_protect_o == EE_MON) else $error("ee");
endmodule : hwo_chk

/* File: testbench/testbench.sv */
// Purpose: Self-checking bench for the option registers
// Assumes: Reads answer exactly one cycle after the strobe
// Notes:   Queue pairs each read with its answer
`timescale 1ns/1ns
module testbench;
    localparam logic [7:0] OPT_A = 8'ha6;
    logic        sys_clk_i = 0, sys_rst_i = 1, wr = 0, rd = 0, mon = 0, sec = 0, rd_d = 0;
    logic [15:0] addr = 16'h0000;
    logic [7:0]  wdata = 8'h00, rdata, exp_v, exp_q[$];
    logic [31:0] lfsr = 32'h2c1e;
    int          err_total = 0, n_compared = 0;
    always #4 sys_clk_i = ~sys_clk_i;
    hwo_option_regs #(.OPTION_A(OPT_A), .EE_CLK(1'b1), .EE_MON(1'b1)) i_hwo_option_regs (.sys_clk_i, .sys_rst_i,
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .monitor_mode_i(mon),
        .sec_code_ok_i(sec), .lowvolt_in_stop_en_o(), .rom_read_protect_o(), .lowvolt_reset_en_o(), .lowvolt_power_en_o(),
        .short_stop_recovery_o(), .stop_recovery_cycles_o(), .watchdog_rate_sel_o(), .watchdog_timeout_cycles_o(),
        .stop_insn_en_o(), .watchdog_disable_o(), .watchdog_enable_o(), .eeprom_timebase_clk_sel_o(),
        .eeprom_monitor_protect_o(), .eeprom_monitor_block_o());
    // Strobes left as set so back-to-back calls never lower and raise in one step
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next
    task automatic acc(input logic w, input logic r, input logic [15:0] a, input logic [7:0] e);
        lfsr = lfsr_next(lfsr);
        addr <= a; wdata <= lfsr[7:0]; wr <= w; rd <= r; mon <= lfsr[8]; sec <= lfsr[9];
        if (r) exp_q.push_back(e);
        @(posedge sys_clk_i);
    endtask : acc
    task automatic give_verdict;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : give_verdict
    always @(posedge sys_clk_i) rd_d <= rd && !sys_rst_i;
    always @(negedge sys_clk_i) begin
        if (rd_d) begin
            exp_v = exp_q.pop_front();
            n_compared++;
            if (rdata !== exp_v) begin
                err_total++;
                $display("[FAIL] reg_rdata_o expected %h seen %h", exp_v, rdata);
            end
        end
    end
    initial begin
        #5000;
        err_total++;
        give_verdict();
    end
    initial begin
        repeat (2) @(posedge sys_clk_i);
        sys_rst_i <= 0;
        for (int i = 0; i < 30; i++) begin
            acc(1, 0, hwo_pkg::OPT_A_ADDR, 8'h00);
            acc(0, 1, hwo_pkg::OPT_A_ADDR, OPT_A);
            acc(1, 0, hwo_pkg::OPT_B_ADDR, 8'h00);
            acc(0, 1, hwo_pkg::OPT_B_ADDR, 8'hc0);
            acc(0, 1, {lfsr[15:8], 8'h40}, 8'h00); // Unmapped reads as zero
        end
        acc(0, 0, 16'h0000, 8'h00);
        $display("test register reads done");
        sys_rst_i <= 1;
        @(posedge sys_clk_i);
        sys_rst_i <= 0;
        acc(0, 1, hwo_pkg::OPT_A_ADDR, OPT_A);
        acc(0, 0, 16'h0000, 8'h00);
        @(posedge sys_clk_i);
        $display("test reset survival done");
        give_verdict();
    end
endmodule : testbench
bind hwo_option_regs hwo_chk #(.OPTION_A(OPTION_A), .EE_CLK(EE_CLK), .EE_MON(EE_MON), .VARIANT(VARIANT)) u_chk (.*);
